/* File: gfx_irq_cfg.svh */
// Summary of operation
// - Three separate active-high level interrupt outputs: GPU, display, serial host.
// - All interrupt outputs are registered on the single system clock.
// - GPU output driven by GPU core causes: bus error, composition done, others.
// - Display core causes: frame done, underrun, DBI config error, bus error, reset done.
// - Four buffer-access-done causes, one per configured input buffer address.
// - Display decoder error cause raised on encoded image data error.
// - Serial host core cause reflects host core status registers for link errors.
// - Tearing effect cause in command mode, per line or per frame.
// - Video mode halt cause when queued command overflows blanking.
`ifndef GFX_IRQ_CFG_SVH
`define GFX_IRQ_CFG_SVH

`define UNIT_CNT 3
`define CAUSE_W 16
`define ADDR_W 8

// Register byte offsets
`define OFS_GPU_STATUS 8'h00
`define OFS_GPU_MASK 8'h04
`define OFS_DC_STATUS 8'h08
`define OFS_DC_MASK 8'h0c
`define OFS_DSI_STATUS 8'h10
`define OFS_DSI_MASK 8'h14
`define OFS_PENDING 8'h18
`define OFS_HOST_ST0 8'h1c
`define OFS_HOST_ST1 8'h20

// GPU cause bits
`define GPU_BUS_ERR 0
`define GPU_COMP_DONE 1
`define GPU_OTHER_LO 2
`define GPU_OTHER_W 4

// Display cause bits
`define DC_FRAME_DONE 0
`define DC_UNDERRUN 1
`define DC_DBI_CFG_ERR 2
`define DC_BUS_ERR 3
`define DC_RESET_DONE 4
`define DC_BUF_LO 5
`define DC_BUF_CNT 4
`define DC_DECODE_ERR 9

// Serial host cause bits
`define DSI_CORE 0
`define DSI_TEAR 1
`define DSI_HALT 2

`define MASK_RST 16'h0000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define ZERO32 32'h0000_0000

`endif

/* File: gfx_irq_pkg.sv */
package gfx_irq_pkg;
  typedef enum logic [1:0] {
    UNIT_GPU = 2'b00,
    UNIT_DC = 2'b01,
    UNIT_DSI = 2'b10
  } unit_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_t;
endpackage

/* File: cause_if.sv */
`timescale 1ns/1ns
`default_nettype none
`include "gfx_irq_cfg.svh"
interface cause_if;
  logic [`CAUSE_W-1:0] events;
  logic [`CAUSE_W-1:0] clr;
  logic [`CAUSE_W-1:0] mask_wr;
  logic mask_we;
  logic [`CAUSE_W-1:0] status;
  logic [`CAUSE_W-1:0] mask;
  logic irq;
  modport bank (input events, clr, mask_wr, mask_we, output status, mask, irq);
  modport ctrl (output events, clr, mask_wr, mask_we, input status, mask, irq);
endinterface
`default_nettype wire

/* File: cause_bank.sv */
`timescale 1ns/1ns
`default_nettype none
`include "gfx_irq_cfg.svh"
module cause_bank
  import gfx_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Cause port
  cause_if.bank c
);
  typedef struct packed {
    logic [`CAUSE_W-1:0] status;
    logic [`CAUSE_W-1:0] mask;
    logic irq;
  } bank_t;

  bank_t s_q;
  bank_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.status = (s_q.status & ~c.clr) | c.events;
    if (c.mask_we) begin
      s_d.mask = c.mask_wr;
    end
    s_d.irq = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{status: '0, mask: `MASK_RST, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign c.status = s_q.status;
  assign c.mask = s_q.mask;
  assign c.irq = s_q.irq;
endmodule // cause_bank
`default_nettype wire

/* File: gfx_irq_top.sv */
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "gfx_irq_cfg.svh"
module gfx_irq_top
  import gfx_irq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // GPU core event pulses
  input wire logic gpu_bus_err,
  input wire logic gpu_comp_done,
  input wire logic [`GPU_OTHER_W-1:0] gpu_other,
  // Display controller event pulses
  input wire logic dc_frame_done,
  input wire logic dc_underrun,
  input wire logic dc_dbi_cfg_err,
  input wire logic dc_bus_err,
  input wire logic dc_reset_done,
  input wire logic [`DC_BUF_CNT-1:0] dc_buf_done,
  input wire logic dc_decode_err,
  // Serial display host
  input wire logic [31:0] host_core_status_0,
  input wire logic [31:0] host_core_status_1,
  input wire logic command_mode,
  input wire logic te_pulse,
  input wire logic cmd_overflow,
  // AXI4-Lite write
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt outputs
  output logic gpu_irq_out,
  output logic display_ctrl_irq_out,
  output logic serial_host_irq_out
);
  typedef struct packed {
    logic aw_have;
    logic [`ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] st0_prev;
    logic [31:0] st1_prev;
    logic [`UNIT_CNT-1:0] irq;
  } top_t;

  top_t s_q;
  top_t s_d;

  cause_if cif [`UNIT_CNT] ();

  logic [`CAUSE_W-1:0] ev [`UNIT_CNT];
  logic [`CAUSE_W-1:0] clr [`UNIT_CNT];
  logic [`CAUSE_W-1:0] mwr [`UNIT_CNT];
  logic [`UNIT_CNT-1:0] mwe;
  logic [`CAUSE_W-1:0] st [`UNIT_CNT];
  logic [`CAUSE_W-1:0] mk [`UNIT_CNT];
  logic [`UNIT_CNT-1:0] irq_w;

  genvar gi;
  generate
    for (gi = 0; gi < `UNIT_CNT; gi++) begin : g_bank
      assign cif[gi].events = ev[gi];
      assign cif[gi].clr = clr[gi];
      assign cif[gi].mask_wr = mwr[gi];
      assign cif[gi].mask_we = mwe[gi];
      assign st[gi] = cif[gi].status;
      assign mk[gi] = cif[gi].mask;
      assign irq_w[gi] = cif[gi].irq;
      cause_bank u_bank (
        .clk(clk),
        .reset_n(reset_n),
        .c(cif[gi])
      );
    end
  endgenerate

  logic core_change;
  logic wr_fire;
  logic [`ADDR_W-1:0] wa;
  logic [31:0] wd;

  always_comb begin
    // Host status changes catch new link errors without decoding the bit layout
    core_change = (host_core_status_0 != s_q.st0_prev) | (host_core_status_1 != s_q.st1_prev);
    ev[0] = '0;
    ev[0][`GPU_BUS_ERR] = gpu_bus_err;
    ev[0][`GPU_COMP_DONE] = gpu_comp_done;
    ev[0][`GPU_OTHER_LO +: `GPU_OTHER_W] = gpu_other;
    ev[1] = '0;
    ev[1][`DC_FRAME_DONE] = dc_frame_done;
    ev[1][`DC_UNDERRUN] = dc_underrun;
    ev[1][`DC_DBI_CFG_ERR] = dc_dbi_cfg_err;
    ev[1][`DC_BUS_ERR] = dc_bus_err;
    ev[1][`DC_RESET_DONE] = dc_reset_done;
    ev[1][`DC_BUF_LO +: `DC_BUF_CNT] = dc_buf_done;
    ev[1][`DC_DECODE_ERR] = dc_decode_err;
    ev[2] = '0;
    ev[2][`DSI_CORE] = core_change;
    ev[2][`DSI_TEAR] = te_pulse & command_mode;
    ev[2][`DSI_HALT] = cmd_overflow & ~command_mode;
  end

  always_comb begin
    s_d = s_q;
    s_d.st0_prev = host_core_status_0;
    s_d.st1_prev = host_core_status_1;
    wa = s_q.aw_addr;
    wd = s_q.w_data;
    for (int u = 0; u < `UNIT_CNT; u++) begin
      clr[u] = '0;
      mwr[u] = mk[u];
    end
    mwe = '0;
    // Write channels accepted independently, one write at a time
    s_d.awready = 1'b0;
    s_d.wready = 1'b0;
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    if (wr_fire) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `RESP_OKAY;
      case (wa)
        `OFS_GPU_STATUS: clr[0] = wd[`CAUSE_W-1:0] & {{8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
        `OFS_DC_STATUS: clr[1] = wd[`CAUSE_W-1:0] & {{8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
        `OFS_DSI_STATUS: clr[2] = wd[`CAUSE_W-1:0] & {{8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
        `OFS_GPU_MASK: begin
          mwe[0] = 1'b1;
          mwr[0] = {s_q.w_strb[1] ? wd[15:8] : mk[0][15:8], s_q.w_strb[0] ? wd[7:0] : mk[0][7:0]};
        end
        `OFS_DC_MASK: begin
          mwe[1] = 1'b1;
          mwr[1] = {s_q.w_strb[1] ? wd[15:8] : mk[1][15:8], s_q.w_strb[0] ? wd[7:0] : mk[1][7:0]};
        end
        `OFS_DSI_MASK: begin
          mwe[2] = 1'b1;
          mwr[2] = {s_q.w_strb[1] ? wd[15:8] : mk[2][15:8], s_q.w_strb[0] ? wd[7:0] : mk[2][7:0]};
        end
        `OFS_PENDING, `OFS_HOST_ST0, `OFS_HOST_ST1: s_d.bresp = `RESP_OKAY;
        default: s_d.bresp = `RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (!s_d.aw_have && !s_q.awready && !s_axi_awvalid) begin
      s_d.awready = 1'b0;
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid && !(s_axi_awvalid && s_q.awready);
    s_d.wready = !s_d.w_have && !s_d.bvalid && !(s_axi_wvalid && s_q.wready);
    // Read: address taken, data one cycle later
    s_d.arready = 1'b0;
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `RESP_OKAY;
      case (s_axi_araddr)
        `OFS_GPU_STATUS: s_d.rdata = {16'h0000, st[0]};
        `OFS_GPU_MASK: s_d.rdata = {16'h0000, mk[0]};
        `OFS_DC_STATUS: s_d.rdata = {16'h0000, st[1]};
        `OFS_DC_MASK: s_d.rdata = {16'h0000, mk[1]};
        `OFS_DSI_STATUS: s_d.rdata = {16'h0000, st[2]};
        `OFS_DSI_MASK: s_d.rdata = {16'h0000, mk[2]};
        `OFS_PENDING: s_d.rdata = {29'h0000_0000, irq_w};
        `OFS_HOST_ST0: s_d.rdata = s_q.st0_prev;
        `OFS_HOST_ST1: s_d.rdata = s_q.st1_prev;
        default: begin
          s_d.rdata = `ZERO32;
          s_d.rresp = `RESP_SLVERR;
        end
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    s_d.arready = !s_d.rvalid && !(s_axi_arvalid && s_q.arready);
    // outputs from flops on system clock
    s_d.irq = irq_w;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign gpu_irq_out = s_q.irq[UNIT_GPU];
  assign display_ctrl_irq_out = s_q.irq[UNIT_DC];
  assign serial_host_irq_out = s_q.irq[UNIT_DSI];
endmodule // gfx_irq_top
`default_nettype wire

/* File: irq_service_model.sv */
`timescale 1ns/1ns
`default_nettype none
module irq_service_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Interrupt lines and service
  input wire logic [2:0] irq,
  input wire logic ack,
  output logic [2:0] seen_q
);
  // Latch until serviced
  // Each seen_q bit stays set from the first edge its irq line is seen high until ack
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_q <= 3'h0;
    end else if (ack) begin
      seen_q <= 3'h0;
    end else begin
      seen_q <= seen_q | irq;
    end
  end
endmodule // irq_service_model
`default_nettype wire

/* File: gfx_irq_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module gfx_irq_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // GPU events
  input wire logic gpu_bus_err,
  input wire logic gpu_comp_done,
  input wire logic [3:0] gpu_other,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt outputs
  input wire logic gpu_irq_out,
  input wire logic display_ctrl_irq_out,
  input wire logic serial_host_irq_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic gev = gpu_bus_err | gpu_comp_done | (|gpu_other);
  chk_reset_quiet: assert property (disable iff (1'h0)
    !reset_n |-> !(gpu_irq_out | display_ctrl_irq_out | serial_host_irq_out)) else $error("irq high in reset");
  // A rise needs a GPU event two edges back or a recent mask write
  chk_gpu_rise: assert property ($rose(gpu_irq_out) |-> $past(gev, 2)
    || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3)) else $error("gpu irq without cause");
  chk_dc_fall: assert property ($fell(display_ctrl_irq_out) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3)) else $error("dc irq fell alone");
  chk_b_delay: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
  chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  chk_r_delay: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answering");
  cov_gpu: cover property ($rose(gpu_irq_out));
  cov_dc: cover property ($rose(display_ctrl_irq_out));
  cov_host: cover property ($rose(serial_host_irq_out));
endmodule // gfx_irq_checker
bind gfx_irq_top gfx_irq_checker gfx_irq_checker_i (.clk, .reset_n, .gpu_bus_err, .gpu_comp_done, .gpu_other,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .gpu_irq_out, .display_ctrl_irq_out, .serial_host_irq_out);
`default_nettype wire

/* File: test_graphics_subsystem_interrupts.sv */
`timescale 1ns/1ns
`default_nettype none
module test_graphics_subsystem_interrupts
  import gfx_irq_pkg::*;
;
  logic clk = 1'h0;
  logic reset_n = 1'h1;
  logic cmd_q = 1'h0;
  logic ack_q = 1'h0;
  logic [18:0] ev_q = 19'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, rd_d;
  logic [2:0] irq, seen;
  int fails = 0;
  int n_compared = 0;
  always #20 clk = ~clk;
  gfx_irq_top gfx_irq_top_i (.clk(clk), .reset_n(reset_n),
    .gpu_bus_err(ev_q[0]), .gpu_comp_done(ev_q[1]), .gpu_other(ev_q[5:2]), .dc_frame_done(ev_q[6]),
    .dc_underrun(ev_q[7]), .dc_dbi_cfg_err(ev_q[8]), .dc_bus_err(ev_q[9]), .dc_reset_done(ev_q[10]),
    .dc_buf_done(ev_q[14:11]), .dc_decode_err(ev_q[15]), .host_core_status_0({31'h0, ev_q[18]}),
    .host_core_status_1({31'h0, ev_q[18]}), .command_mode(cmd_q), .te_pulse(ev_q[16]), .cmd_overflow(ev_q[17]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .gpu_irq_out(irq[0]), .display_ctrl_irq_out(irq[1]), .serial_host_irq_out(irq[2]));
  irq_service_model irq_service_model_i (.clk(clk), .reset_n(reset_n), .irq(irq), .ack(ack_q), .seen_q(seen));
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("mismatch t=%0t resp got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (!wd && wready) begin
        wd = 1'h1;
        wvalid <= 1'h0;
      end
    end
    while (!bvalid) @(posedge clk);
    rsp = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    @(posedge clk);
    while (!arready) @(posedge clk);
    arvalid <= 1'h0;
    @(posedge clk);
    while (!rvalid) @(posedge clk);
    rd_d = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask
  task automatic pulse(input logic [18:0] v);
    ev_q <= v;
    @(posedge clk);
    ev_q <= 19'h0;
    repeat (4) @(posedge clk);
  endtask
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict;
  end
  initial begin
    logic [31:0] rows [19];
    logic m;
    logic [4:0] e;
    logic [5:0] o;
    logic [15:0] s;
    logic [3:0] x;
    // Row: mode, event bit, status offset, status, irq vector shifted left
    rows = '{{1'h0, 5'h00, 6'h00, 16'h0001, 4'h2}, {1'h0, 5'h01, 6'h00, 16'h0002, 4'h2},
      {1'h0, 5'h02, 6'h00, 16'h0004, 4'h2}, {1'h0, 5'h05, 6'h00, 16'h0020, 4'h2},
      {1'h0, 5'h06, 6'h08, 16'h0001, 4'h4}, {1'h0, 5'h07, 6'h08, 16'h0002, 4'h4},
      {1'h0, 5'h08, 6'h08, 16'h0004, 4'h4}, {1'h0, 5'h09, 6'h08, 16'h0008, 4'h4},
      {1'h0, 5'h0a, 6'h08, 16'h0010, 4'h4}, {1'h0, 5'h0b, 6'h08, 16'h0020, 4'h4},
      {1'h0, 5'h0c, 6'h08, 16'h0040, 4'h4}, {1'h0, 5'h0d, 6'h08, 16'h0080, 4'h4},
      {1'h0, 5'h0e, 6'h08, 16'h0100, 4'h4}, {1'h0, 5'h0f, 6'h08, 16'h0200, 4'h4},
      {1'h1, 5'h10, 6'h10, 16'h0002, 4'h8}, {1'h0, 5'h10, 6'h10, 16'h0000, 4'h0},
      {1'h0, 5'h11, 6'h10, 16'h0004, 4'h8}, {1'h1, 5'h11, 6'h10, 16'h0000, 4'h0},
      {1'h0, 5'h12, 6'h10, 16'h0001, 4'h8}};
    // A real falling edge at time zero, so the flops clear before the first clock
    reset_n <= 1'h0;
    repeat (8) @(posedge clk);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk);
    rd(8'h0c);
    chk_val(rd_d, 32'h0);
    rd(8'h24);
    chk_val(rd_d, 32'h0);
    chk_resp(rsp, 2'h2);
    wr(8'h24, 32'h1);
    chk_resp(rsp, 2'h2);
    $display("test reset and unmapped done");
    pulse(19'h40);
    chk_val(32'(irq), 32'h0);
    rd(8'h08);
    chk_val(rd_d, 32'h1);
    chk_resp(rsp, 2'h0);
    wr(8'h08, 32'h1);
    rd(8'h08);
    chk_val(rd_d, 32'h0);
    for (int k = 0; k < 3; k++) begin
      wr(8'h04 + 8'(k * 8), 32'hffff_ffff);
      rd(8'h04 + 8'(k * 8));
      chk_val(rd_d, 32'h0000_ffff);
    end
    $display("test masked cause done");
    foreach (rows[i]) begin
      {m, e, o, s, x} = rows[i];
      cmd_q <= m;
      pulse(19'h1 << e);
      chk_val(32'(irq), 32'(x[3:1]));
      chk_val(32'(seen), 32'(x[3:1]));
      rd({2'h0, o});
      chk_val(rd_d, {16'h0, s});
      rd(8'h18);
      chk_val(rd_d, 32'(x[3:1]));
      ack_q <= 1'h1;
      wr({2'h0, o}, {16'h0, s});
      repeat (3) @(posedge clk);
      chk_val(32'(irq), 32'h0);
      ack_q <= 1'h0;
    end
    $display("test cause table done");
    pulse(19'h1);
    chk_val(32'(irq), 32'h1);
    reset_n <= 1'h0;
    @(posedge clk);
    chk_val(32'(irq), 32'h0);
    repeat (7) @(posedge clk);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk);
    rd(8'h04);
    chk_val(rd_d, 32'h0);
    $display("test mid-run reset done");
    // Host status words read back; the change cause sets but stays masked
    ev_q <= 19'h4_0000;
    rd(8'h1c);
    chk_val(rd_d, 32'h1);
    rd(8'h20);
    chk_val(rd_d, 32'h1);
    ev_q <= 19'h0;
    rd(8'h10);
    chk_val(rd_d, 32'h1);
    chk_val(32'(irq), 32'h0);
    // Low byte strobe only touches mask bits 7:0
    wstrb <= 4'h1;
    wr(8'h04, 32'h0000_ffff);
    wstrb <= 4'hf;
    rd(8'h04);
    chk_val(rd_d, 32'h0000_00ff);
    $display("test host status and strobes done");
    give_verdict;
  end
endmodule // test_graphics_subsystem_interrupts
`default_nettype wire
